// *** verilog/iocc_consts.svh ***
// constants of the i/o configuration check and register block
`ifndef IOCC_CONSTS_SVH
`define IOCC_CONSTS_SVH
`define IOCC_NSLOT 8
`define IOCC_IDX_W 3
`define IOCC_LAST_IDX 3'h7
`define IOCC_IDX_ZERO 3'h0
`define IOCC_IDX_ONE 3'h1
`define IOCC_ADDR_W 10
`define IOCC_FIRST_REF 10'h001
`define IOCC_MAX_REF 11'h3FF
`define IOCC_LEN_NARROW 11'h010
`define IOCC_LEN_WIDE 11'h020
`define IOCC_CART_AW 4
`define IOCC_CART_DW 16
`define IOCC_SEL_REG 1'b0
`define IOCC_SEL_MAP 1'b1
`define IOCC_REG_PAD 11'h000
`define IOCC_MAP_PAD 3'h0
`define IOCC_REG_MSB 4
`define IOCC_MAP_MSB 12
`define IOCC_CMP_MSB 3
`define IOCC_REF_ONE 11'h001
`endif

// *** verilog/iocc_pkg.sv ***
// types of the i/o configuration check and register block
package iocc_pkg;
	typedef struct packed {
		logic present;
		logic is_out;
		logic wide;
		logic [1:0] model;
	} iocc_slot_t;
	typedef struct packed {
		logic assigned;
		logic is_out;
		logic wide;
		logic [9:0] addr;
	} iocc_map_t;
	typedef struct packed {
		logic valid;
		logic [2:0] slot;
		iocc_map_t entry;
	} iocc_dl_t;
	typedef enum logic [3:0] {
		IOCC_IDLE = 4'h0,
		IOCC_SCAN = 4'h1,
		IOCC_LDREG = 4'h3,
		IOCC_LDMAP = 4'h2,
		IOCC_CHECK = 4'h6,
		IOCC_VALID = 4'h7,
		IOCC_STOP = 4'h5,
		IOCC_RUN = 4'h4,
		IOCC_HOLD = 4'hC,
		IOCC_COMMIT = 4'hD,
		IOCC_ALLOC = 4'hF,
		IOCC_WRMAP = 4'hE,
		IOCC_WRREG = 4'hA
	} iocc_state_t;
endpackage : iocc_pkg

// *** verilog/iocc_top.sv ***
// i/o configuration check, commit and map validation controller
// Function
// - at power-up copy the stored assignment map from cartridge into working memory
// - detect modules removed, inserted or no longer responding against the recorded set
// - raise mismatch only if checking enabled and configurations differ
// - check order: scan rack, load registration, then load assignment map
// - validate map after check and commit: duplicates, overlaps, out-of-range addresses
// - same check runs at power-up and on every stop-to-run change
// - without mismatch go straight on to normal operation
// - show a detected mismatch to the host as an error
// - commit records added modules and drops removed ones in registration
// - commit gives addresses to installed unaddressed modules in the map
// - commit writes map to cartridge first, registration second, then validates
// - temporary accept skips commit steps yet allows running until power cycle
// - self-allocated addresses start at first input and first output reference
// - after temporary accept the mismatch reappears at power-up, staying stopped
`include "iocc_consts.svh"
module iocc_top (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic run_req_i,
	input wire logic check_enable_i,
	input wire logic commit_cmd_i,
	input wire logic accept_temporary_configuration_cmd_i,
	input wire iocc_pkg::iocc_dl_t assignment_map_download_i,
	input wire iocc_pkg::iocc_slot_t [`IOCC_NSLOT-1:0] rack_slot_i,
	input wire logic cart_ack_i,
	input wire logic [`IOCC_CART_DW-1:0] cart_rdata_i,
	output logic cart_req_o,
	output logic cart_we_o,
	output logic [`IOCC_CART_AW-1:0] cart_addr_o,
	output logic [`IOCC_CART_DW-1:0] cart_wdata_o,
	output logic running_o,
	output logic busy_o,
	output logic cfg_mismatch_o,
	output logic temp_accepted_o,
	output logic map_dup_o,
	output logic map_overlap_o,
	output logic map_range_o
);
	// ==========================================================
	// reset release
	logic rst_meta_r;
	logic rst_sync_n;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n <= rst_meta_r;
		end
	end

	// ==========================================================
	// state and storage
	iocc_pkg::iocc_state_t state_r, state_nxt;
	iocc_pkg::iocc_slot_t [`IOCC_NSLOT-1:0] live_r;
	iocc_pkg::iocc_slot_t [`IOCC_NSLOT-1:0] reg_mem_r;
	iocc_pkg::iocc_map_t [`IOCC_NSLOT-1:0] map_r;
	logic [`IOCC_IDX_W-1:0] idx_r, idx_nxt;
	logic [`IOCC_ADDR_W-1:0] next_in_r, next_out_r;
	logic mis_r, temp_ok_r, dl_done_r;
	logic cart_req_r, cart_we_r, running_r, busy_r;
	logic [`IOCC_CART_AW-1:0] cart_addr_r;
	logic [`IOCC_CART_DW-1:0] cart_wdata_r;
	logic dup_r, ovl_r, rng_r;

	// ==========================================================
	// decode
	wire last_w = (idx_r == `IOCC_LAST_IDX);
	wire beat_w = cart_req_r && cart_ack_i;
	wire done_w = beat_w && last_w;
	wire dl_ok_w = assignment_map_download_i.valid &&
		((state_r == iocc_pkg::IOCC_STOP) || (state_r == iocc_pkg::IOCC_HOLD));
	wire cmd_ok_w = (state_r == iocc_pkg::IOCC_STOP) || (state_r == iocc_pkg::IOCC_HOLD);
	wire cart_nxt_w = (state_nxt == iocc_pkg::IOCC_LDREG) || (state_nxt == iocc_pkg::IOCC_LDMAP) ||
		(state_nxt == iocc_pkg::IOCC_WRMAP) || (state_nxt == iocc_pkg::IOCC_WRREG);
	wire we_nxt_w = (state_nxt == iocc_pkg::IOCC_WRMAP) || (state_nxt == iocc_pkg::IOCC_WRREG);
	wire sel_nxt_w = (state_nxt == iocc_pkg::IOCC_LDMAP) || (state_nxt == iocc_pkg::IOCC_WRMAP) ?
		`IOCC_SEL_MAP : `IOCC_SEL_REG;
	wire [`IOCC_CART_DW-1:0] wdata_nxt_w = (sel_nxt_w == `IOCC_SEL_MAP) ?
		{`IOCC_MAP_PAD, map_r[idx_nxt]} : {`IOCC_REG_PAD, reg_mem_r[idx_nxt]};
	wire iocc_pkg::iocc_slot_t alloc_slot_w = live_r[idx_r];
	wire alloc_need_w = alloc_slot_w.present && !map_r[idx_r].assigned;
	wire [`IOCC_ADDR_W-1:0] alloc_addr_w = alloc_slot_w.is_out ? next_out_r : next_in_r;
	wire [`IOCC_ADDR_W:0] alloc_len_w = alloc_slot_w.wide ? `IOCC_LEN_WIDE : `IOCC_LEN_NARROW;
	wire [`IOCC_ADDR_W-1:0] alloc_next_w = alloc_addr_w + alloc_len_w[`IOCC_ADDR_W-1:0];

	// slot-wise comparison of live against recorded configuration
	logic diff_c;
	logic cover_c;
	always_comb begin
		diff_c = 1'b0;
		cover_c = 1'b1;
		for (int i = 0; i < `IOCC_NSLOT; i++) begin
			if (live_r[i].present != reg_mem_r[i].present) diff_c = 1'b1;
			else if (live_r[i].present && (live_r[i][`IOCC_CMP_MSB:0] != reg_mem_r[i][`IOCC_CMP_MSB:0]))
				diff_c = 1'b1;
			if (live_r[i].present && !map_r[i].assigned) cover_c = 1'b0;
		end
	end

	// map validation; a range of one kind must not share a reference with another of that kind
	logic [`IOCC_ADDR_W:0] end_c [`IOCC_NSLOT];
	logic dup_c, ovl_c, rng_c;
	always_comb begin
		dup_c = 1'b0;
		ovl_c = 1'b0;
		rng_c = 1'b0;
		for (int i = 0; i < `IOCC_NSLOT; i++) begin
			end_c[i] = {1'b0, map_r[i].addr} + (map_r[i].wide ? `IOCC_LEN_WIDE : `IOCC_LEN_NARROW) - `IOCC_REF_ONE;
		end
		for (int i = 0; i < `IOCC_NSLOT; i++) begin
			if (map_r[i].assigned) begin
				if ((map_r[i].addr < `IOCC_FIRST_REF) || (end_c[i] > `IOCC_MAX_REF)) rng_c = 1'b1;
				for (int j = i + 1; j < `IOCC_NSLOT; j++) begin
					if (map_r[j].assigned && (map_r[j].is_out == map_r[i].is_out)) begin
						if (map_r[j].addr == map_r[i].addr) dup_c = 1'b1;
						else if (({1'b0, map_r[i].addr} <= end_c[j]) && ({1'b0, map_r[j].addr} <= end_c[i]))
							ovl_c = 1'b1;
					end
				end
			end
		end
	end

	// ==========================================================
	// sequence control
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			iocc_pkg::IOCC_IDLE: state_nxt = iocc_pkg::IOCC_SCAN;
			iocc_pkg::IOCC_SCAN: state_nxt = iocc_pkg::IOCC_LDREG;
			iocc_pkg::IOCC_LDREG: if (done_w) state_nxt = iocc_pkg::IOCC_LDMAP;
			iocc_pkg::IOCC_LDMAP: if (done_w) state_nxt = iocc_pkg::IOCC_CHECK;
			iocc_pkg::IOCC_CHECK: state_nxt = iocc_pkg::IOCC_VALID;
			iocc_pkg::IOCC_VALID: begin
				if (mis_r) state_nxt = iocc_pkg::IOCC_HOLD;
				else if (run_req_i) state_nxt = iocc_pkg::IOCC_RUN;
				else state_nxt = iocc_pkg::IOCC_STOP;
			end
			iocc_pkg::IOCC_STOP: begin
				if (commit_cmd_i) state_nxt = iocc_pkg::IOCC_COMMIT;
				else if (run_req_i) state_nxt = iocc_pkg::IOCC_SCAN;
			end
			iocc_pkg::IOCC_RUN: if (!run_req_i) state_nxt = iocc_pkg::IOCC_STOP;
			iocc_pkg::IOCC_HOLD: begin
				if (commit_cmd_i) state_nxt = iocc_pkg::IOCC_COMMIT;
				else if (accept_temporary_configuration_cmd_i) state_nxt = iocc_pkg::IOCC_STOP;
				else if (dl_done_r && cover_c) state_nxt = iocc_pkg::IOCC_STOP;
			end
			iocc_pkg::IOCC_COMMIT: state_nxt = iocc_pkg::IOCC_ALLOC;
			iocc_pkg::IOCC_ALLOC: if (last_w) state_nxt = iocc_pkg::IOCC_WRMAP;
			iocc_pkg::IOCC_WRMAP: if (done_w) state_nxt = iocc_pkg::IOCC_WRREG;
			iocc_pkg::IOCC_WRREG: if (done_w) state_nxt = iocc_pkg::IOCC_VALID;
			default: state_nxt = iocc_pkg::IOCC_IDLE;
		endcase
	end

	always_comb begin
		if (state_nxt != state_r) idx_nxt = `IOCC_IDX_ZERO;
		else if (beat_w || (state_r == iocc_pkg::IOCC_ALLOC)) idx_nxt = idx_r + `IOCC_IDX_ONE;
		else idx_nxt = idx_r;
	end

	// ==========================================================
	// registers
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_r <= iocc_pkg::IOCC_IDLE;
			idx_r <= `IOCC_IDX_ZERO;
			cart_req_r <= 1'b0;
			cart_we_r <= 1'b0;
			cart_addr_r <= '0;
			cart_wdata_r <= '0;
			running_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			cart_req_r <= cart_nxt_w;
			cart_we_r <= we_nxt_w;
			cart_addr_r <= {sel_nxt_w, idx_nxt};
			cart_wdata_r <= wdata_nxt_w;
			running_r <= (state_nxt == iocc_pkg::IOCC_RUN);
			busy_r <= (state_nxt != iocc_pkg::IOCC_RUN) && (state_nxt != iocc_pkg::IOCC_STOP) &&
				(state_nxt != iocc_pkg::IOCC_HOLD);
		end
	end

	// temporary acceptance lives only until the next reset
	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mis_r <= 1'b0;
			temp_ok_r <= 1'b0;
			dl_done_r <= 1'b0;
		end else begin
			if (state_r == iocc_pkg::IOCC_CHECK) mis_r <= check_enable_i && !temp_ok_r && diff_c;
			else if (state_r == iocc_pkg::IOCC_HOLD && state_nxt != iocc_pkg::IOCC_HOLD) mis_r <= 1'b0;
			if (state_r == iocc_pkg::IOCC_HOLD && accept_temporary_configuration_cmd_i && !commit_cmd_i)
				temp_ok_r <= 1'b1;
			if (state_r != iocc_pkg::IOCC_HOLD) dl_done_r <= 1'b0;
			else if (dl_ok_w) dl_done_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			live_r <= '0;
			reg_mem_r <= '0;
			map_r <= '0;
			next_in_r <= `IOCC_FIRST_REF;
			next_out_r <= `IOCC_FIRST_REF;
			dup_r <= 1'b0;
			ovl_r <= 1'b0;
			rng_r <= 1'b0;
		end else begin
			if (state_r == iocc_pkg::IOCC_SCAN) live_r <= rack_slot_i;
			if (state_r == iocc_pkg::IOCC_LDREG && beat_w) reg_mem_r[idx_r] <= cart_rdata_i[`IOCC_REG_MSB:0];
			if (state_r == iocc_pkg::IOCC_LDMAP && beat_w) map_r[idx_r] <= cart_rdata_i[`IOCC_MAP_MSB:0];
			if (state_r == iocc_pkg::IOCC_COMMIT) begin
				live_r <= rack_slot_i;
				reg_mem_r <= rack_slot_i;
				next_in_r <= `IOCC_FIRST_REF;
				next_out_r <= `IOCC_FIRST_REF;
			end
			if (state_r == iocc_pkg::IOCC_ALLOC && alloc_need_w) begin
				map_r[idx_r] <= {1'b1, alloc_slot_w.is_out, alloc_slot_w.wide, alloc_addr_w};
				if (alloc_slot_w.is_out) next_out_r <= alloc_next_w;
				else next_in_r <= alloc_next_w;
			end
			if (dl_ok_w) map_r[assignment_map_download_i.slot] <= assignment_map_download_i.entry;
			if (state_r == iocc_pkg::IOCC_VALID) begin
				dup_r <= dup_c;
				ovl_r <= ovl_c;
				rng_r <= rng_c;
			end
		end
	end

	assign cart_req_o = cart_req_r;
	assign cart_we_o = cart_we_r;
	assign cart_addr_o = cart_addr_r;
	assign cart_wdata_o = cart_wdata_r;
	assign running_o = running_r;
	assign busy_o = busy_r;
	assign cfg_mismatch_o = mis_r;
	assign temp_accepted_o = temp_ok_r;
	assign map_dup_o = dup_r;
	assign map_overlap_o = ovl_r;
	assign map_range_o = rng_r;

	// ==========================================================
	// checks
	AST_SCAN_FIRST: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_SCAN |=> state_r == iocc_pkg::IOCC_LDREG && cart_req_r && !cart_we_r)
		else $error("scan not followed by registration load");
	AST_CHECK_OFF: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_CHECK && !check_enable_i |=> !mis_r)
		else $error("mismatch raised with check disabled");
	AST_DIFF_FLAG: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_CHECK && check_enable_i && !temp_ok_r && diff_c |=> mis_r ##1 cfg_mismatch_o)
		else $error("difference not flagged");
	AST_NO_PAUSE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_VALID && !mis_r && run_req_i |=> running_o)
		else $error("clean check did not run");
	AST_HOLD_ERR: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_VALID && mis_r |=> state_r == iocc_pkg::IOCC_HOLD && !running_o && cfg_mismatch_o)
		else $error("mismatch not held");
	AST_REGISTER: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_COMMIT |=> reg_mem_r == $past(rack_slot_i))
		else $error("registration not updated");
	AST_ALLOC: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_ALLOC && alloc_need_w |=> map_r[$past(idx_r)].assigned)
		else $error("address not allocated");
	AST_FIRST_REF: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_COMMIT |=> next_in_r == `IOCC_FIRST_REF && next_out_r == `IOCC_FIRST_REF)
		else $error("allocation start wrong");
	AST_WR_ORDER: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_WRMAP && done_w |=> state_r == iocc_pkg::IOCC_WRREG && cart_we_o &&
		cart_addr_o == {`IOCC_SEL_REG, `IOCC_IDX_ZERO})
		else $error("map not written before registration");
	AST_TEMP: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_HOLD && accept_temporary_configuration_cmd_i && !commit_cmd_i |=>
		state_r == iocc_pkg::IOCC_STOP && temp_ok_r && !cart_req_o && !cfg_mismatch_o)
		else $error("temporary accept misbehaved");
	AST_VALIDATE: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_VALID |=> map_dup_o == $past(dup_c) && map_overlap_o == $past(ovl_c))
		else $error("validation result not captured");
	AST_RESTART: assert property (@(posedge mclk_i) disable iff (!rst_sync_n)
		state_r == iocc_pkg::IOCC_STOP && run_req_i && !commit_cmd_i |=> state_r == iocc_pkg::IOCC_SCAN)
		else $error("stop-to-run skipped the check");
endmodule : iocc_top

// *** testbench/iocc_cart_model.sv ***
// memory cartridge model: holds registration and assignment map words
module iocc_cart_model (
	input wire logic mclk_i,
	input wire logic cart_req_i,
	input wire logic cart_we_i,
	input wire logic [3:0] cart_addr_i,
	input wire logic [15:0] cart_wdata_i,
	output logic cart_ack_o,
	output logic [15:0] cart_rdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] mem [16];
	logic [4:0] log_addr [256];
	int n_acc;
	int wait_cnt;
	logic slow;
	// ==========================================
	// stored content: slot0 input, slot1 output, both at first reference
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
		mem[0] = 16'h0010;
		mem[1] = 16'h0018;
		mem[8] = 16'h1001;
		mem[9] = 16'h1801;
		cart_ack_o = 1'b0;
		cart_rdata_o = 16'h0000;
		n_acc = 0;
		wait_cnt = 0;
		slow = 1'b0;
	end
	// ==========================================
	// answers alternate prompt and slow; idle data keeps changing
	always @(posedge mclk_i) begin
		if (cart_ack_o) begin
			cart_ack_o <= 1'b0;
			cart_rdata_o <= ~cart_rdata_o;
		end else if (cart_req_i && wait_cnt < (slow ? 2 : 0)) begin
			wait_cnt <= wait_cnt + 1;
		end else if (cart_req_i) begin
			wait_cnt <= 0;
			slow <= ~slow;
			cart_ack_o <= 1'b1;
			log_addr[n_acc] <= {cart_we_i, cart_addr_i};
			n_acc <= n_acc + 1;
			if (cart_we_i) mem[cart_addr_i] <= cart_wdata_i;
			else cart_rdata_o <= mem[cart_addr_i];
		end else begin
			cart_rdata_o <= ~cart_rdata_o;
		end
	end
endmodule : iocc_cart_model

// *** testbench/test_iocc_top.sv ***
// self-checking bench of the configuration check and commit controller
module test_iocc_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0, rst_n = 1'b0, run_req = 1'b1, chk_en = 1'b1, commit = 1'b0, accept = 1'b0;
	iocc_pkg::iocc_dl_t dl = '0;
	iocc_pkg::iocc_slot_t [7:0] rack = {30'h0, 5'h18, 5'h10};
	logic ack, req, we, running, busy, mism, temp, dup, ovl, rng;
	logic [3:0] addr;
	logic [15:0] rdata, wdata;
	int fail_count = 0, total_checks = 0, nb;
	initial forever #2 mclk = ~mclk;
	iocc_top iocc_top_inst (.mclk_i(mclk), .rst_n_i(rst_n), .run_req_i(run_req), .check_enable_i(chk_en),
		.commit_cmd_i(commit), .accept_temporary_configuration_cmd_i(accept), .assignment_map_download_i(dl),
		.rack_slot_i(rack), .cart_ack_i(ack), .cart_rdata_i(rdata), .cart_req_o(req), .cart_we_o(we),
		.cart_addr_o(addr), .cart_wdata_o(wdata), .running_o(running), .busy_o(busy), .cfg_mismatch_o(mism),
		.temp_accepted_o(temp), .map_dup_o(dup), .map_overlap_o(ovl), .map_range_o(rng));
	iocc_cart_model iocc_cart_model_inst (.mclk_i(mclk), .cart_req_i(req), .cart_we_i(we), .cart_addr_i(addr),
		.cart_wdata_i(wdata), .cart_ack_o(ack), .cart_rdata_o(rdata));
	// ==========================================
	// helpers
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// bounded wait until the sequence has finished
	task settle;
		int i;
		repeat (5) @(posedge mclk);
		i = 0;
		while (busy !== 1'b0 && i < 300) begin
			@(posedge mclk);
			i++;
		end
		if (i >= 300) begin
			chk(16'h0001, 16'h0000, "sequence hung");
			end_of_test();
		end else begin
			#1;
		end
	endtask : settle
	// eight logged cartridge accesses, ascending slots
	task chk_log(input int base, input logic wr, input logic [3:0] first);
		for (int i = 0; i < 8; i++)
			chk({11'h000, iocc_cart_model_inst.log_addr[base + i]}, {11'h000, wr, first + 4'(i)}, "cart order");
	endtask : chk_log
	// one-cycle command strobe: commit when do_commit, temporary accept otherwise
	task pulse(input logic do_commit);
		@(posedge mclk);
		if (do_commit) commit <= 1'b1;
		else accept <= 1'b1;
		@(posedge mclk);
		commit <= 1'b0;
		accept <= 1'b0;
		settle();
	endtask : pulse
	task restart_run;
		@(posedge mclk);
		run_req <= 1'b0;
		settle();
		@(posedge mclk);
		run_req <= 1'b1;
		settle();
	endtask : restart_run
	task dl_entry(input logic [2:0] slot, input logic [9:0] a);
		@(posedge mclk);
		dl <= '{valid: 1'b1, slot: slot, entry: '{assigned: 1'b1, is_out: 1'b0, wide: 1'b0, addr: a}};
		@(posedge mclk);
		dl.valid <= 1'b0;
	endtask : dl_entry
	task chk_state(input logic r, input logic m, input logic t);
		chk({15'h0000, running}, {15'h0000, r}, "running");
		chk({15'h0000, mism}, {15'h0000, m}, "mismatch");
		chk({15'h0000, temp}, {15'h0000, t}, "temp accept");
	endtask : chk_state
	// ==========================================
	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		settle();
		chk_log(0, 1'b0, 4'h0);
		chk_log(8, 1'b0, 4'h8);
		chk_state(1'b1, 1'b0, 1'b0);
		chk({13'h0000, dup, ovl, rng}, 16'h0000, "clean map flags");
		$display("test power_up_clean done");
		@(posedge mclk);
		rack[2] <= 5'h10;
		restart_run();
		chk_state(1'b0, 1'b1, 1'b0);
		$display("test insert_detect done");
		nb = iocc_cart_model_inst.n_acc;
		pulse(1'b1);
		chk_log(nb, 1'b1, 4'h8);
		chk_log(nb + 8, 1'b1, 4'h0);
		chk(iocc_cart_model_inst.mem[10], 16'h1001, "allocated ref");
		chk(iocc_cart_model_inst.mem[2], 16'h0010, "registered slot");
		chk({15'h0000, dup}, 16'h0001, "duplicate flag");
		chk_state(1'b1, 1'b0, 1'b0);
		$display("test commit done");
		@(posedge mclk);
		chk_en <= 1'b0;
		rack[1] <= 5'h00;
		restart_run();
		chk_state(1'b1, 1'b0, 1'b0);
		@(posedge mclk);
		chk_en <= 1'b1;
		restart_run();
		chk_state(1'b0, 1'b1, 1'b0);
		$display("test check_enable done");
		pulse(1'b0);
		chk_state(1'b1, 1'b0, 1'b1);
		chk(iocc_cart_model_inst.mem[1], 16'h0018, "no write on accept");
		$display("test temp_accept done");
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		settle();
		chk_state(1'b0, 1'b1, 1'b0);
		$display("test power_cycle done");
		@(posedge mclk);
		run_req <= 1'b0;
		dl_entry(3'h2, 10'h011);
		settle();
		chk_state(1'b0, 1'b0, 1'b0);
		dl_entry(3'h0, 10'h3F8);
		pulse(1'b1);
		chk(iocc_cart_model_inst.mem[10], 16'h1011, "user ref kept");
		chk(iocc_cart_model_inst.mem[1], 16'h0000, "removed slot dropped");
		chk({13'h0000, dup, ovl, rng}, 16'h0001, "range flag only");
		chk_state(1'b0, 1'b0, 1'b0);
		$display("test user_map done");
		// slot 2 moved so its range runs into slot 0's: overlap without duplicate
		dl_entry(3'h2, 10'h3F0);
		pulse(1'b1);
		chk(iocc_cart_model_inst.mem[10], 16'h13F0, "moved user ref");
		chk({13'h0000, dup, ovl, rng}, 16'h0003, "overlap flag");
		$display("test overlap done");
		end_of_test();
	end
endmodule : test_iocc_top
